// File: logic/cef_map.svh
`ifndef CEF_MAP_SVH
`define CEF_MAP_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CEF_AW           8
`define CEF_OFF_FLAGS    8'h00
`define CEF_OFF_ENABLES  8'h04

// ****************************************************************
// Field positions
// ****************************************************************
// Status vector index, bit 13 down to bit 8 of the flag register
`define CEF_STAT_LSB     8
`define CEF_STAT_W       6
`define CEF_ST_BUS_OFF   5
`define CEF_ST_TX_PASS   4
`define CEF_ST_RX_PASS   3
`define CEF_ST_TX_WARN   2
`define CEF_ST_RX_WARN   1
`define CEF_ST_ANY_WARN  0
// Flag and enable positions, bits 7 down to 0
`define CEF_FL_W         8
`define CEF_FL_INVALID   7
`define CEF_FL_WAKE      6
`define CEF_FL_ERR       5
`define CEF_FL_UNUSED    4
`define CEF_FL_FIFO      3
`define CEF_FL_OVF       2
`define CEF_FL_RXB       1
`define CEF_FL_TXB       0
`define CEF_FL_MASK      8'hEF
`define CEF_EN_MASK      8'hEF
`define CEF_REG_W        16

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define CEF_RST_FLAGS    8'h00
`define CEF_RST_ENABLES  8'h00
`define CEF_RST_STAT     6'h00
`define CEF_RESP_OKAY    2'h0
`define CEF_RESP_SLVERR  2'h2

`endif

// File: logic/cef_pkg.sv
package cef_pkg;
  `include "cef_map.svh"

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef logic [`CEF_FL_W-1:0] cef_flags_t;

  typedef struct packed {
    logic meta;
    logic sync;
  } cef_rsync_s;

  typedef struct packed {
    cef_flags_t              flags;
    cef_flags_t              enables;
    logic [`CEF_STAT_W-1:0]  stat;
    logic                    irq;
    logic                    aw_have;
    logic [`CEF_AW-1:0]      aw_addr;
    logic                    w_have;
    logic [`CEF_REG_W-1:0]   w_data;
    logic                    w_lane0;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } cef_state_s;

  // Reset image of the whole state
  localparam cef_state_s CEF_STATE_RESET = '{
    flags:   `CEF_RST_FLAGS,
    enables: `CEF_RST_ENABLES,
    stat:    `CEF_RST_STAT,
    bresp:   `CEF_RESP_OKAY,
    rresp:   `CEF_RESP_OKAY,
    default: '0
  };
endpackage : cef_pkg

// File: logic/cef_rst_sync.sv
`timescale 1ns/1ps
module cef_rst_sync
  import cef_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      rstn_o
);
  cef_rsync_s q;
  cef_rsync_s d;

  // Shift a constant one in after release
  always_comb begin
    d.meta = 1'b1;
    d.sync = q.meta;
  end

  // Assert at once, release through two flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rstn_o = q.sync;
endmodule : cef_rst_sync

// File: logic/cef_irq_regs.sv
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module cef_irq_regs
  import cef_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  // Error state levels from the protocol engine
  input  wire logic                tx_bus_off_state_i,
  input  wire logic                tx_passive_state_i,
  input  wire logic                rx_passive_state_i,
  input  wire logic                tx_warning_state_i,
  input  wire logic                rx_warning_state_i,
  // One-cycle event pulses
  input  wire logic                invalid_msg_evt_i,
  input  wire logic                wake_activity_evt_i,
  input  wire logic                fifo_almost_full_evt_i,
  input  wire logic                rx_overflow_evt_i,
  input  wire logic                rx_buffer_evt_i,
  input  wire logic                tx_buffer_evt_i,
  // AXI4-Lite slave
  input  wire logic [`CEF_AW-1:0]  s_axi_awaddr_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  output logic [1:0]               s_axi_bresp_o,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  input  wire logic [`CEF_AW-1:0]  s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  // Combined interrupt request
  output logic                     irq_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_n;

  cef_rst_sync u_rst_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .rstn_o (rst_n)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  cef_state_s             q;
  cef_state_s             d;
  logic                   wr_go;
  logic                   wr_flags;
  logic                   wr_enables;
  logic                   rd_go;
  cef_flags_t             set_v;
  cef_flags_t             keep_v;
  logic [`CEF_REG_W-1:0]  rd_word;

  always_comb begin
    d          = q;
    wr_go      = 1'b0;
    wr_flags   = 1'b0;
    wr_enables = 1'b0;
    rd_go      = 1'b0;
    set_v      = '0;
    keep_v     = '1;
    rd_word    = '0;

    // Error state levels, bit 13 down to bit 8
    d.stat[`CEF_ST_BUS_OFF]  = tx_bus_off_state_i;
    d.stat[`CEF_ST_TX_PASS]  = tx_passive_state_i;
    d.stat[`CEF_ST_RX_PASS]  = rx_passive_state_i;
    d.stat[`CEF_ST_TX_WARN]  = tx_warning_state_i;
    d.stat[`CEF_ST_RX_WARN]  = rx_warning_state_i;
    d.stat[`CEF_ST_ANY_WARN] = tx_warning_state_i | rx_warning_state_i;

    // Hardware set sources
    set_v[`CEF_FL_INVALID] = invalid_msg_evt_i;
    set_v[`CEF_FL_WAKE]    = wake_activity_evt_i;
    set_v[`CEF_FL_ERR]     = |(d.stat & ~q.stat);
    set_v[`CEF_FL_FIFO]    = fifo_almost_full_evt_i;
    set_v[`CEF_FL_OVF]     = rx_overflow_evt_i;
    set_v[`CEF_FL_RXB]     = rx_buffer_evt_i;
    set_v[`CEF_FL_TXB]     = tx_buffer_evt_i;

    // Write address and data are taken independently
    if (s_axi_awvalid_i && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && q.wready) begin
      d.w_have  = 1'b1;
      d.w_data  = s_axi_wdata_i[`CEF_REG_W-1:0];
      d.w_lane0 = s_axi_wstrb_i[0];
    end

    // Retire the response
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end

    // Perform the write once both halves are held
    if (q.aw_have && q.w_have && !q.bvalid) begin
      wr_go      = 1'b1;
      wr_flags   = (q.aw_addr == `CEF_OFF_FLAGS) && q.w_lane0;
      wr_enables = (q.aw_addr == `CEF_OFF_ENABLES) && q.w_lane0;
      d.aw_have  = 1'b0;
      d.w_have   = 1'b0;
      d.bvalid   = 1'b1;
      if ((q.aw_addr == `CEF_OFF_FLAGS) || (q.aw_addr == `CEF_OFF_ENABLES)) begin
        d.bresp = `CEF_RESP_OKAY;
      end else begin
        d.bresp = `CEF_RESP_SLVERR;
      end
    end

    // Only a written zero clears; a written one keeps
    if (wr_flags) begin
      keep_v = q.w_data[`CEF_FL_W-1:0];
    end

    // Set wins over clear; unimplemented bit stays zero
    d.flags = ((q.flags & keep_v) | set_v) & `CEF_FL_MASK;

    // Enables: one per flag, wake included
    if (wr_enables) begin
      d.enables = q.w_data[`CEF_FL_W-1:0] & `CEF_EN_MASK;
    end

    // Combined request, set flags gated by their enables
    d.irq = |(d.flags & d.enables);

    // Retire the read data
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end

    // Read: answer one cycle after the address is taken
    if (s_axi_arvalid_i && q.arready) begin
      rd_go    = 1'b1;
      d.rvalid = 1'b1;
      d.rresp  = `CEF_RESP_OKAY;
      if (s_axi_araddr_i == `CEF_OFF_FLAGS) begin
        rd_word[`CEF_STAT_LSB +: `CEF_STAT_W] = q.stat;
        rd_word[`CEF_FL_W-1:0]                = q.flags;
      end else if (s_axi_araddr_i == `CEF_OFF_ENABLES) begin
        rd_word[`CEF_FL_W-1:0]                = q.enables;
      end else begin
        d.rresp = `CEF_RESP_SLVERR;
      end
      d.rdata = {16'h0000, rd_word};
    end

    // Channels stay closed while a transfer is pending
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Everything clears to its reset image
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= CEF_STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register
  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o  = q.wready;
  assign s_axi_bvalid_o  = q.bvalid;
  assign s_axi_bresp_o   = q.bresp;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rvalid_o  = q.rvalid;
  assign s_axi_rdata_o   = q.rdata;
  assign s_axi_rresp_o   = q.rresp;
  assign irq_o           = q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  property p_bus_off;
    $past(rst_n) |-> q.stat[`CEF_ST_BUS_OFF] == $past(tx_bus_off_state_i);
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus-off status wrong");

  property p_tx_pass;
    $past(rst_n) |-> q.stat[`CEF_ST_TX_PASS] == $past(tx_passive_state_i);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx passive wrong");

  property p_rx_pass;
    $past(rst_n) |-> q.stat[`CEF_ST_RX_PASS] == $past(rx_passive_state_i);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx passive wrong");

  property p_warn;
    $past(rst_n) |-> q.stat[`CEF_ST_TX_WARN] == $past(tx_warning_state_i)
                  && q.stat[`CEF_ST_RX_WARN] == $past(rx_warning_state_i);
  endproperty
  a_warn: assert property (p_warn) else $error("warning status wrong");

  property p_any_warn;
    $past(rst_n) |-> q.stat[`CEF_ST_ANY_WARN]
                     == ($past(tx_warning_state_i) | $past(rx_warning_state_i));
  endproperty
  a_any_warn: assert property (p_any_warn) else $error("combined warning wrong");

  property p_evt_sets;
    invalid_msg_evt_i && tx_buffer_evt_i |=> q.flags[`CEF_FL_INVALID] && q.flags[`CEF_FL_TXB];
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("event lost");

  property p_err_rise;
    $past(rst_n) && |(q.stat & ~$past(q.stat)) |-> q.flags[`CEF_FL_ERR];
  endproperty
  a_err_rise: assert property (p_err_rise) else $error("error flag not set");

  property p_unimpl;
    !q.flags[`CEF_FL_UNUSED] && !q.enables[`CEF_FL_UNUSED] && q.rdata[31:14] == 18'h0_0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

  property p_en_write;
    wr_enables |=> q.enables == ($past(q.w_data[`CEF_FL_W-1:0]) & `CEF_EN_MASK);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write wrong");

  property p_one_keeps;
    wr_flags && q.flags[`CEF_FL_RXB] && q.w_data[`CEF_FL_RXB] |=> q.flags[`CEF_FL_RXB];
  endproperty
  a_one_keeps: assert property (p_one_keeps) else $error("write one cleared");

  property p_set_wins;
    wr_flags && !q.w_data[`CEF_FL_OVF] && rx_overflow_evt_i |=> q.flags[`CEF_FL_OVF];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_irq;
    $past(rst_n) |-> q.irq == |(q.flags & q.enables);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_bresp_time;
    wr_go |=> q.bvalid;
  endproperty
  a_bresp_time: assert property (p_bresp_time) else $error("late write answer");

  property p_rresp_time;
    rd_go |=> q.rvalid ##0 (q.rresp == `CEF_RESP_OKAY
                                    || q.rresp == `CEF_RESP_SLVERR);
  endproperty
  a_rresp_time: assert property (p_rresp_time) else $error("late read answer");

  property p_wake_set;
    wake_activity_evt_i |=> q.flags[`CEF_FL_WAKE];
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

  property p_fifo_set;
    fifo_almost_full_evt_i |=> q.flags[`CEF_FL_FIFO];
  endproperty
  a_fifo_set: assert property (p_fifo_set) else $error("fifo flag not set");

  property p_ovf_set;
    rx_overflow_evt_i |=> q.flags[`CEF_FL_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_rxb_set;
    rx_buffer_evt_i |=> q.flags[`CEF_FL_RXB];
  endproperty
  a_rxb_set: assert property (p_rxb_set) else $error("rx buffer flag not set");

  // A flag may only fall after a write to the flag register
  property p_no_stray_clear;
    $past(rst_n) && !$past(wr_flags) |-> (q.flags & $past(q.flags)) == $past(q.flags);
  endproperty
  a_no_stray_clear: assert property (p_no_stray_clear) else $error("flag lost");

  property p_zero_clears;
    wr_flags && !q.w_data[`CEF_FL_TXB] && !tx_buffer_evt_i |=> !q.flags[`CEF_FL_TXB];
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("zero did not clear");

  property p_en_hold;
    $past(rst_n) && !$past(wr_enables) |-> $stable(q.enables);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enables changed unwritten");

  property p_rd_en;
    rd_go && s_axi_araddr_i == `CEF_OFF_ENABLES |=> q.rdata == {24'h00_0000, $past(q.enables)};
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable read wrong");

  // Each answer is retired by exactly one accepted handshake
  property p_b_retire;
    q.bvalid && s_axi_bready_i |=> !q.bvalid;
  endproperty
  a_b_retire: assert property (p_b_retire) else $error("write answer not retired");

  property p_r_retire;
    q.rvalid && s_axi_rready_i |=> !q.rvalid;
  endproperty
  a_r_retire: assert property (p_r_retire) else $error("read answer not retired");

  c_irq_rise: cover property ($rose(q.irq));
  c_set_clear: cover property (wr_flags && |set_v);
  c_slverr: cover property (q.rvalid && q.rresp == `CEF_RESP_SLVERR);
  c_bus_off: cover property ($rose(q.stat[`CEF_ST_BUS_OFF]));

endmodule : cef_irq_regs

// File: verif/can_error_state_interrupt_flags_test.sv
`timescale 1ns/1ps
`include "cef_map.svh"
module can_error_state_interrupt_flags_test
  import cef_pkg::*;
;
  // ****************************************************************
  // Bench signals and tables
  // ****************************************************************
  localparam logic [7:0]  A_FL  = `CEF_OFF_FLAGS;
  localparam logic [7:0]  A_EN  = `CEF_OFF_ENABLES;
  localparam logic [31:0] OKAY  = 32'h0000_0000;
  localparam logic [31:0] SLV   = 32'h0000_0002;
  // Flag bit of each event line, evt index order
  localparam logic [31:0] FEXP [6] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004,
                                       32'h0000_0008, 32'h0000_0040, 32'h0000_0080};
  // Status bits of each state line, st index order
  localparam logic [31:0] SEXP [5] = '{32'h0000_0300, 32'h0000_0500, 32'h0000_0800,
                                       32'h0000_1000, 32'h0000_2000};
  logic        clk_i;
  logic        rstn_i;
  logic [4:0]  st;      // 4 bus off, 3 tx pass, 2 rx pass, 1 tx warn, 0 rx warn
  logic [5:0]  evt;     // 5 invalid, 4 wake, 3 fifo, 2 ovf, 1 rx buf, 0 tx buf
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        irq_o;
  logic [31:0] d;
  logic [1:0]  r;
  logic [5:0]  wr_evt;  // Event lines raised for the cycle in which a write lands
  int          err_total;
  int          n_compared;

  cef_irq_regs i_cef_irq_regs (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .tx_bus_off_state_i(st[4]), .tx_passive_state_i(st[3]), .rx_passive_state_i(st[2]),
    .tx_warning_state_i(st[1]), .rx_warning_state_i(st[0]),
    .invalid_msg_evt_i(evt[5]), .wake_activity_evt_i(evt[4]),
    .fifo_almost_full_evt_i(evt[3]), .rx_overflow_evt_i(evt[2]),
    .rx_buffer_evt_i(evt[1]), .tx_buffer_evt_i(evt[0]),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .irq_o(irq_o)
  );

  // Free running 50 MHz clock
  always #10 clk_i = ~clk_i;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t ns: seen 0x%08h expected 0x%08h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Write cycle: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s,
                    output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= dat;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Optional event pulse in the cycle the design performs the write
    if (wr_evt != 6'h00) begin
      evt <= wr_evt;
      @(posedge clk_i);
      evt <= 6'h00;
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  // Read cycle: data and response taken at the edge that retires rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // One-cycle pulse on the chosen event lines
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_i);
    evt <= m;
    @(posedge clk_i);
    evt <= 6'h00;
  endtask : pulse

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(A_FL, d, r);
    check(d, 32'h0000_0000);
    check(32'(r), OKAY);
    rd(A_EN, d, r);
    check(d, 32'h0000_0000);
    check(32'(irq_o), 32'h0000_0000);
  endtask : t_reset

  task automatic t_enables();
    wr(A_EN, 32'hFFFF_FFFF, 4'hF, r);
    check(32'(r), OKAY);
    rd(A_EN, d, r);
    check(d, 32'h0000_00EF);
    wr(A_EN, 32'h0000_0000, 4'h0, r);
    rd(A_EN, d, r);
    check(d, 32'h0000_00EF);
    wr(A_EN, 32'h0000_0000, 4'h1, r);
    rd(A_EN, d, r);
    check(d, 32'h0000_0000);
  endtask : t_enables

  // Each event alone, then all at once, writes of one keep, zero clears
  task automatic t_events();
    for (int i = 0; i < 6; i++) begin
      pulse(6'(1 << i));
      rd(A_FL, d, r);
      check(d, FEXP[i]);
      check(32'(irq_o), 32'h0000_0000);
      wr(A_FL, 32'h0000_0000, 4'h1, r);
    end
    pulse(6'h3F);
    wr(A_FL, 32'hFFFF_FFFF, 4'hF, r);
    rd(A_FL, d, r);
    check(d, 32'h0000_00CF);
    wr(A_FL, 32'h0000_0000, 4'h1, r);
    rd(A_FL, d, r);
    check(d, 32'h0000_0000);
  endtask : t_events

  task automatic t_irq();
    wr(A_EN, 32'h0000_0002, 4'h1, r);
    pulse(6'h01);
    rd(A_FL, d, r);
    check(32'(irq_o), 32'h0000_0000);
    pulse(6'h02);
    rd(A_FL, d, r);
    check(32'(irq_o), 32'h0000_0001);
    wr(A_FL, 32'h0000_0001, 4'h1, r);
    rd(A_FL, d, r);
    check(d, 32'h0000_0001);
    check(32'(irq_o), 32'h0000_0000);
    wr(A_EN, 32'h0000_0001, 4'h1, r);
    check(32'(irq_o), 32'h0000_0001);
    wr(A_FL, 32'h0000_0000, 4'h1, r);
    wr(A_EN, 32'h0000_0040, 4'h1, r);
    pulse(6'h10);
    rd(A_FL, d, r);
    check(32'(irq_o), 32'h0000_0001);
    wr(A_FL, 32'h0000_0000, 4'h1, r);
    check(32'(irq_o), 32'h0000_0000);
  endtask : t_irq

  // Each state line alone: status bits follow, error flag latches once
  task automatic t_status();
    wr(A_EN, 32'h0000_0020, 4'h1, r);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      st <= 5'(1 << i);
      rd(A_FL, d, r);
      check(d, SEXP[i] | 32'h0000_0020);
      check(32'(irq_o), 32'h0000_0001);
      wr(A_FL, 32'h0000_FFDF, 4'h3, r);
      rd(A_FL, d, r);
      check(d, SEXP[i]);
      @(posedge clk_i);
      st <= 5'h00;
      rd(A_FL, d, r);
      check(d, 32'h0000_0000);
    end
    wr(A_EN, 32'h0000_0000, 4'h1, r);
  endtask : t_status

  // Overflow event in the very cycle a zero is written must survive it
  task automatic t_set_wins();
    wr_evt = 6'h04;
    wr(A_FL, 32'h0000_0000, 4'h1, r);
    wr_evt = 6'h00;
    rd(A_FL, d, r);
    check(d, 32'h0000_0004);
    wr(A_FL, 32'h0000_0000, 4'h1, r);
    rd(A_FL, d, r);
    check(d, 32'h0000_0000);
  endtask : t_set_wins

  task automatic t_unmapped();
    wr(A_EN, 32'h0000_0041, 4'h1, r);
    wr(8'h08, 32'hFFFF_FFFF, 4'hF, r);
    check(32'(r), SLV);
    rd(8'h08, d, r);
    check(d, 32'h0000_0000);
    check(32'(r), SLV);
    rd(8'h05, d, r);
    check(32'(r), SLV);
    rd(A_EN, d, r);
    check(d, 32'h0000_0041);
  endtask : t_unmapped

  // Main sequence: reset for 20 cycles, then every scenario in turn
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    st = '0;
    evt = '0;
    wr_evt = '0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_enables();
    t_events();
    t_irq();
    t_status();
    t_set_wins();
    t_unmapped();
    stop_test();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    stop_test();
  end
endmodule : can_error_state_interrupt_flags_test
